// ===== design/amg_pkg.sv
// Constants, types and register map of the converter input control block
package amg_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_CTRL  = 5'h00;  // Converter control register
   localparam logic [4:0] OFS_CFG   = 5'h04;  // Converter config register
   localparam logic [4:0] OFS_CHSEL = 5'h08;  // Channel select register
   localparam logic [4:0] OFS_PAIR  = 5'h0c;  // Pair config register
   localparam logic [4:0] OFS_REF   = 5'h10;  // Reference control register
   localparam logic [4:0] OFS_STAT  = 5'h14;  // Read-only block status

   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_EN_BIT  = 0;  // converter_enable_bit
   localparam int unsigned REF_BIAS_BIT = 0;  // bias_enable_bit
   localparam int unsigned GAIN_W       = 3;  // amp_gain_field width
   localparam int unsigned CH_W         = 4;  // Channel number width
   localparam int unsigned PAIRS        = 4;  // External input pairs
   localparam int unsigned GAIN_N       = 6;  // Selectable gains

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic              RST_EN     = 1'b0;
   localparam logic              RST_BIAS   = 1'b0;
   localparam logic [CH_W-1:0]   RST_CHSEL  = 4'h0;
   localparam logic [PAIRS-1:0]  RST_PAIR   = 4'h0;  // All single-ended
   localparam logic [GAIN_W-1:0] RST_GAIN   = 3'h0;  // Unity gain

   // ----------------------------------------------------------------
   // Channel and gain encodings
   // ----------------------------------------------------------------
   localparam logic [CH_W-1:0] CH_TEMP = 4'h8;  // Internal temperature sensor

   typedef enum logic [GAIN_W-1:0] {
      AMG_GAIN_X1   = 3'h0,
      AMG_GAIN_X2   = 3'h1,
      AMG_GAIN_X4   = 3'h2,
      AMG_GAIN_X8   = 3'h3,
      AMG_GAIN_X16  = 3'h4,
      AMG_GAIN_XP5  = 3'h5
   } amg_gain_t;

   // One-hot gain select: [0]=0.5 [1]=1 [2]=2 [3]=4 [4]=8 [5]=16
   localparam logic [GAIN_N-1:0] GAIN_OH_UNITY = 6'h02;

   // ----------------------------------------------------------------
   // Converter figures and sample pacing
   // ----------------------------------------------------------------
   localparam int unsigned SAR_BITS      = 12;     // Converter resolution
   localparam int unsigned CLK_PERIOD_NS = 20;     // 50 MHz system clock
   localparam int unsigned RATE_KSPS     = 100;    // Peak throughput
   localparam int unsigned SAMPLE_NS     = 1000000 / RATE_KSPS;
   // Shortest spacing rounds down; at least one cycle
   localparam int unsigned SAMPLE_CYC    = (SAMPLE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                           SAMPLE_NS / CLK_PERIOD_NS;
   localparam int unsigned PACE_W        = 9;

endpackage

// ===== design/amg_route_if.sv
// Carrier between the register core and the multiplexer/gain decoder
`timescale 1ns/100ps
interface amg_route_if;
   import amg_pkg::*;

   logic [CH_W-1:0]   ch_sel;     // Channel select register value
   logic [PAIRS-1:0]  pair_cfg;   // Pair config register value
   logic [GAIN_W-1:0] gain_code;  // amp_gain_field value
   logic [CH_W-1:0]   pos_ch;     // Positive input routed to the amplifier
   logic [CH_W-1:0]   neg_ch;     // Negative input when differential
   logic              neg_gnd;    // Negative side tied to analog ground
   logic              diff;       // Differential pair in use
   logic              temp;       // Temperature sensor routed
   logic [GAIN_N-1:0] gain_oh;    // One-hot amplifier gain

   modport core (output ch_sel, pair_cfg, gain_code,
                 input  pos_ch, neg_ch, neg_gnd, diff, temp, gain_oh);
   modport dec  (input  ch_sel, pair_cfg, gain_code,
                 output pos_ch, neg_ch, neg_gnd, diff, temp, gain_oh);
endinterface

// ===== design/amg_route_dec.sv
// Decoder from channel, pair and gain settings to analog routing selects
`timescale 1ns/100ps
module amg_route_dec (
   amg_route_if.dec r
);
   import amg_pkg::*;

   // ----------------------------------------------------------------
   // Gain code to one-hot amplifier select
   // ----------------------------------------------------------------
   function automatic logic [GAIN_N-1:0] gain_onehot(input logic [GAIN_W-1:0] code);
      case (code)
         AMG_GAIN_XP5 : gain_onehot = 6'h01;
         AMG_GAIN_X1  : gain_onehot = 6'h02;
         AMG_GAIN_X2  : gain_onehot = 6'h04;
         AMG_GAIN_X4  : gain_onehot = 6'h08;
         AMG_GAIN_X8  : gain_onehot = 6'h10;
         AMG_GAIN_X16 : gain_onehot = 6'h20;
         default      : gain_onehot = GAIN_OH_UNITY;  // Spare codes act as unity
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Routing decode
   // ----------------------------------------------------------------
   // Channels above the sensor fold onto the sensor so no code leaves
   // the amplifier input floating.
   always_comb begin
      logic is_temp;
      logic pair_diff;
      is_temp   = (r.ch_sel >= CH_TEMP);
      pair_diff = r.pair_cfg[r.ch_sel[2:1]];
      r.temp    = is_temp;
      r.diff    = !is_temp && pair_diff;
      if (is_temp) begin
         r.pos_ch  = CH_TEMP;
         r.neg_ch  = 4'h0;
         r.neg_gnd = 1'b1;
      end else if (pair_diff) begin
         // Either channel of a differential pair selects even(+), odd(-)
         r.pos_ch  = {r.ch_sel[3:1], 1'b0};
         r.neg_ch  = {r.ch_sel[3:1], 1'b1};
         r.neg_gnd = 1'b0;
      end else begin
         r.pos_ch  = r.ch_sel;
         r.neg_ch  = 4'h0;
         r.neg_gnd = 1'b1;
      end
      // Gain is the same whichever channel is routed
      r.gain_oh = gain_onehot(r.gain_code);
   end

endmodule // amg_route_dec

// ===== design/amg_top.sv
// Converter input multiplexer, gain and power control with Avalon-MM slave
// Operation
// - Converter, track-hold, amplifier run only when enabled.
// - Enable clear keeps subsystem in low-power shutdown.
// - Nine channels: eight external, one temperature sensor.
// - Gain applies equally to temperature sensor.
// - Each pair single-ended or differential, changeable anytime.
// - After reset all pairs single-ended.
// - Mux controlled by channel and pair registers.
// - Three-bit gain field selects 0.5 to 16.
// - Gain resets to unity.
// - Twelve-bit converter paced at 100 ksps maximum.
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
module amg_top (
   input  wire logic                         clk,                // System clock, 50 MHz
   input  wire logic                         rst_n,              // Async reset, active low
   input  wire logic [4:0]                   avs_address,        // Byte address
   input  wire logic                         avs_read,           // Read request
   input  wire logic                         avs_write,          // Write request
   input  wire logic [31:0]                  avs_writedata,      // Write data
   input  wire logic [3:0]                   avs_byteenable,     // Byte lanes
   output logic      [31:0]                  avs_readdata,       // Read data
   output logic                              avs_waitrequest,    // Stall
   output logic                              conv_enable,        // Converter powered
   output logic                              track_hold_enable,  // Track-hold powered
   output logic                              amp_enable,         // Amplifier powered
   output logic                              shutdown,           // Low-power shutdown
   output logic                              bias_on,            // Bias supplied
   output logic                              conv_ready,         // Enabled and biased
   output logic                              sample_tick,        // Paced sample slot
   output logic      [amg_pkg::CH_W-1:0]     mux_pos,            // Positive input select
   output logic      [amg_pkg::CH_W-1:0]     mux_neg,            // Negative input select
   output logic                              mux_neg_gnd,        // Negative side grounded
   output logic                              mux_diff,           // Differential routing
   output logic                              temp_sel,           // Sensor routed
   output logic      [amg_pkg::GAIN_N-1:0]   amp_gain_sel        // One-hot gain
);
   import amg_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic               waitrequest;  // Bus stall, high while idle
      logic [31:0]        readdata;     // Captured read word
      logic               ctrl_en;      // converter_enable_bit
      logic               bias_en;      // bias_enable_bit
      logic [GAIN_W-1:0]  gain_code;    // amp_gain_field
      logic [CH_W-1:0]    ch_sel;       // Channel select register
      logic [PAIRS-1:0]   pair_cfg;     // Pair config register
      logic [PACE_W-1:0]  pace_cnt;     // Sample slot counter
      logic               conv_en;      // Registered power outputs
      logic               th_en;
      logic               amp_en;
      logic               sdn;
      logic               bias;
      logic               ready;
      logic               tick;
      logic [CH_W-1:0]    pos;          // Registered routing outputs
      logic [CH_W-1:0]    neg;
      logic               neg_gnd;
      logic               diff;
      logic               temp;
      logic [GAIN_N-1:0]  gain_oh;
   } amg_state_t;

   localparam amg_state_t ST_RESET = '{
      waitrequest : 1'b1,
      readdata    : 32'h0000_0000,
      ctrl_en     : RST_EN,
      bias_en     : RST_BIAS,
      gain_code   : RST_GAIN,
      ch_sel      : RST_CHSEL,
      pair_cfg    : RST_PAIR,
      pace_cnt    : '0,
      conv_en     : 1'b0,
      th_en       : 1'b0,
      amp_en      : 1'b0,
      sdn         : 1'b1,
      bias        : 1'b0,
      ready       : 1'b0,
      tick        : 1'b0,
      pos         : RST_CHSEL,
      neg         : 4'h0,
      neg_gnd     : 1'b1,
      diff        : 1'b0,
      temp        : 1'b0,
      gain_oh     : GAIN_OH_UNITY
   };

   localparam logic [PACE_W-1:0] PACE_LAST = PACE_W'(SAMPLE_CYC - 1);

   amg_state_t st;        // Current state
   amg_state_t next_st;   // Next state
   logic [1:0] rst_sync;  // Reset release synchroniser
   logic       rst_q_n;   // Synchronised reset

   amg_route_if route ();  // Settings out, routing back

   // ----------------------------------------------------------------
   // Reset synchroniser
   // ----------------------------------------------------------------
   // Assert at once, release two edges later so no flop sees a
   // release that straddles a clock edge.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_q_n = rst_sync[1];

   // ----------------------------------------------------------------
   // Routing decoder
   // ----------------------------------------------------------------
   // Only these two registers and the gain field steer the mux
   assign route.ch_sel    = st.ch_sel;
   assign route.pair_cfg  = st.pair_cfg;
   assign route.gain_code = st.gain_code;

   amg_route_dec u_dec (
      .r (route.dec)
   );

   // ----------------------------------------------------------------
   // Register read decode
   // ----------------------------------------------------------------
   // Unmapped addresses read zero; reserved bits read zero
   function automatic logic [31:0] reg_read(input amg_state_t s, input logic [4:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         OFS_CTRL  : d[CTRL_EN_BIT]  = s.ctrl_en;
         OFS_CFG   : d[GAIN_W-1:0]   = s.gain_code;
         OFS_CHSEL : d[CH_W-1:0]     = s.ch_sel;
         OFS_PAIR  : d[PAIRS-1:0]    = s.pair_cfg;
         OFS_REF   : d[REF_BIAS_BIT] = s.bias_en;
         OFS_STAT  : d = {10'h000, s.gain_oh, s.pos, s.neg, s.temp, s.diff,
                          s.neg_gnd, s.sdn, s.tick, s.ready, s.bias, s.conv_en};
         default   : d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic req;
      logic wr_lane0;
      wr_lane0 = 1'b0;
      next_st  = st;
      req      = avs_read || avs_write;

      // Bus: stall one cycle, then answer with waitrequest low for one
      // cycle; the master completes on that edge.
      next_st.waitrequest = 1'b1;
      if (req && st.waitrequest) begin
         next_st.waitrequest = 1'b0;
         next_st.readdata    = reg_read(st, avs_address);
      end

      // Writes commit on the edge where the master sees waitrequest low.
      // Every field sits in byte lane 0, so only that lane matters.
      wr_lane0 = avs_write && !st.waitrequest && avs_byteenable[0];
      if (wr_lane0) begin
         case (avs_address)
            OFS_CTRL  : next_st.ctrl_en   = avs_writedata[CTRL_EN_BIT];
            OFS_CFG   : next_st.gain_code = avs_writedata[GAIN_W-1:0];
            OFS_CHSEL : next_st.ch_sel    = avs_writedata[CH_W-1:0];
            // Pair modes may change while converting
            OFS_PAIR  : next_st.pair_cfg  = avs_writedata[PAIRS-1:0];
            OFS_REF   : next_st.bias_en   = avs_writedata[REF_BIAS_BIT];
            default   : next_st.ctrl_en   = st.ctrl_en;  // Status and holes ignore writes
         endcase
      end

      // Converter, track-hold and amplifier power follow the enable bit alone; bias follows bias_enable_bit
      next_st.conv_en = st.ctrl_en;
      next_st.th_en   = st.ctrl_en;
      next_st.amp_en  = st.ctrl_en;
      next_st.sdn     = !st.ctrl_en;
      next_st.bias    = st.bias_en;
      // Without bias the converter cannot run, so it is never ready
      next_st.ready   = st.ctrl_en && st.bias_en;

      // Sample slots no closer than the peak conversion rate allows
      next_st.tick = 1'b0;
      if (!st.ready) begin
         next_st.pace_cnt = '0;
      end else if (st.pace_cnt == PACE_LAST) begin
         next_st.pace_cnt = '0;
         next_st.tick     = 1'b1;
      end else begin
         next_st.pace_cnt = st.pace_cnt + 1'b1;
      end

      // Routing registered so every output comes from a flop
      next_st.pos     = route.pos_ch;
      next_st.neg     = route.neg_ch;
      next_st.neg_gnd = route.neg_gnd;
      next_st.diff    = route.diff;
      next_st.temp    = route.temp;
      next_st.gain_oh = route.gain_oh;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset puts pairs single-ended and gain at unity
   always_ff @(posedge clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign avs_readdata      = st.readdata;
   assign avs_waitrequest   = st.waitrequest;
   assign conv_enable       = st.conv_en;
   assign track_hold_enable = st.th_en;
   assign amp_enable        = st.amp_en;
   assign shutdown          = st.sdn;
   assign bias_on           = st.bias;
   assign conv_ready        = st.ready;
   assign sample_tick       = st.tick;
   assign mux_pos           = st.pos;
   assign mux_neg           = st.neg;
   assign mux_neg_gnd       = st.neg_gnd;
   assign mux_diff          = st.diff;
   assign temp_sel          = st.temp;
   assign amp_gain_sel      = st.gain_oh;

endmodule // amg_top

// ===== bench/amg_top_asserts.sv
// Concurrent checks on the ports of the converter input control block
`timescale 1ns/100ps
module amg_top_asserts import amg_pkg::*; (
   input wire logic                       clk,
   input wire logic                       rst_n,
   input wire logic                       avs_read,
   input wire logic                       avs_write,
   input wire logic                       avs_waitrequest,
   input wire logic                       conv_enable,
   input wire logic                       track_hold_enable,
   input wire logic                       amp_enable,
   input wire logic                       shutdown,
   input wire logic                       bias_on,
   input wire logic                       conv_ready,
   input wire logic                       sample_tick,
   input wire logic [amg_pkg::CH_W-1:0]   mux_pos,
   input wire logic [amg_pkg::CH_W-1:0]   mux_neg,
   input wire logic                       mux_neg_gnd,
   input wire logic                       mux_diff,
   input wire logic                       temp_sel,
   input wire logic [amg_pkg::GAIN_N-1:0] amp_gain_sel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // Tick spacing counter
   // ----------------------------------------------------------------
   logic [8:0] gap;   // Cycles since the last tick
   logic       seen;  // A tick has happened since ready rose
   // First tick timing is left to the bench; only repeats are counted here
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap  <= 9'h000;
         seen <= 1'b0;
      end else if (!conv_ready) begin
         gap  <= 9'h000;
         seen <= 1'b0;
      end else if (sample_tick) begin
         gap  <= 9'h000;
         seen <= 1'b1;
      end else begin
         gap <= gap + 9'h001;
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_units_follow: assert property (track_hold_enable == conv_enable
      && amp_enable == conv_enable) else $error("power units disagree");
   a_shutdown_inv: assert property (shutdown != conv_enable)
      else $error("shutdown not inverse of enable");
   a_ready_gate: assert property (conv_ready |-> conv_enable && bias_on)
      else $error("ready without enable and bias");
   a_tick_ready: assert property (sample_tick |-> conv_ready)
      else $error("tick while not ready");
   a_tick_gap: assert property (sample_tick && seen |-> gap == 9'd499)
      else $error("tick spacing wrong");
   a_tick_late: assert property (seen |-> gap <= 9'd499)
      else $error("tick overdue");
   a_gain_onehot: assert property ($onehot(amp_gain_sel))
      else $error("gain select not one-hot");
   a_temp_route: assert property (temp_sel |-> mux_pos == CH_TEMP
      && mux_neg_gnd && !mux_diff) else $error("sensor routing wrong");
   a_diff_route: assert property (mux_diff |-> !mux_neg_gnd && !mux_pos[0]
      && mux_neg == mux_pos + 4'h1) else $error("differential routing wrong");
   a_single_gnd: assert property (!mux_diff |-> mux_neg_gnd && mux_neg == 4'h0)
      else $error("single-ended routing wrong");
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("no answer after one wait");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
endmodule // amg_top_asserts

bind amg_top amg_top_asserts chk_u (.clk(clk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .conv_enable(conv_enable),
   .track_hold_enable(track_hold_enable), .amp_enable(amp_enable), .shutdown(shutdown),
   .bias_on(bias_on), .conv_ready(conv_ready), .sample_tick(sample_tick),
   .mux_pos(mux_pos), .mux_neg(mux_neg), .mux_neg_gnd(mux_neg_gnd), .mux_diff(mux_diff),
   .temp_sel(temp_sel), .amp_gain_sel(amp_gain_sel));

// ===== bench/amg_top_tb.sv
// Self-checking bench for the converter input control block
`timescale 1ns/100ps
module amg_top_tb;
   import amg_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_readdata, q;
   logic        avs_waitrequest, conv_enable, track_hold_enable, amp_enable, shutdown;
   logic        bias_on, conv_ready, sample_tick, mux_neg_gnd, mux_diff, temp_sel;
   logic [3:0]  mux_pos, mux_neg;
   logic [5:0]  amp_gain_sel;
   int          n_fail = 0, compares = 0, n;
   // One row: channel, pair bits, gain code, expected status[21:5]
   typedef struct packed { logic [3:0] ch, pair; logic [2:0] g; logic [16:0] e; } amg_row_t;
   amg_row_t rows [10] = '{
      '{4'h0, 4'h0, 3'h0, {6'h02, 4'h0, 4'h0, 3'b001}}, '{4'h1, 4'h1, 3'h1, {6'h04, 4'h0, 4'h1, 3'b010}},
      '{4'h3, 4'h2, 3'h2, {6'h08, 4'h2, 4'h3, 3'b010}}, '{4'h5, 4'h0, 3'h3, {6'h10, 4'h5, 4'h0, 3'b001}},
      '{4'h6, 4'h8, 3'h4, {6'h20, 4'h6, 4'h7, 3'b010}}, '{4'h7, 4'h0, 3'h5, {6'h01, 4'h7, 4'h0, 3'b001}},
      '{4'h8, 4'hf, 3'h1, {6'h04, 4'h8, 4'h0, 3'b101}}, '{4'h4, 4'h4, 3'h6, {6'h02, 4'h4, 4'h5, 3'b010}},
      '{4'h2, 4'h0, 3'h7, {6'h02, 4'h2, 4'h0, 3'b001}}, '{4'hf, 4'h0, 3'h0, {6'h02, 4'h8, 4'h0, 3'b101}}};

   always #10 clk = ~clk;  // 50 MHz

   amg_top dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .conv_enable(conv_enable), .track_hold_enable(track_hold_enable),
      .amp_enable(amp_enable), .shutdown(shutdown), .bias_on(bias_on),
      .conv_ready(conv_ready), .sample_tick(sample_tick), .mux_pos(mux_pos),
      .mux_neg(mux_neg), .mux_neg_gnd(mux_neg_gnd), .mux_diff(mux_diff),
      .temp_sel(temp_sel), .amp_gain_sel(amp_gain_sel));

   // Verdict and end of run
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // One Avalon transfer; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] rd);
      int k;
      @(posedge clk);
      avs_address <= a; avs_write <= wr; avs_read <= !wr;
      avs_writedata <= d; avs_byteenable <= be;
      k = 0;
      do begin @(posedge clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
      rd = avs_readdata;
      avs_read <= 1'b0; avs_write <= 1'b0;
      if (k >= 50) begin n_fail++; $display("MISMATCH at %0t: bus hang", $time); finish_test(); end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] tmp;
      bus(1'b1, a, d, 4'hf, tmp);
   endtask

   // Compare a pin group or a count
   task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++; $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Read a register and compare the word
   task automatic chk_rd(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] got;
      bus(1'b0, a, 32'h0, 4'hf, got);
      chk_pin(got, exp, "register read");
   endtask

   // Hang guard
   initial begin #1000000; n_fail++; $display("MISMATCH at %0t: timeout", $time); finish_test(); end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk); #1;
      // Reset values on pins and registers
      chk_pin({conv_enable, track_hold_enable, amp_enable, shutdown, bias_on, conv_ready},
              6'b000100, "reset power");
      chk_pin({amp_gain_sel, mux_pos, mux_neg, temp_sel, mux_diff, mux_neg_gnd},
              {6'h02, 4'h0, 4'h0, 3'b001}, "reset route");
      for (int i = 0; i < 5; i++) chk_rd(5'(i * 4), 32'h0);
      chk_rd(OFS_STAT, 32'h0002_0030);
      // Refusals: lane 0 off, read-only status; unmapped place reads zero
      wr(OFS_CFG, 32'hffff_fff3);
      chk_rd(OFS_CFG, 32'h3);
      bus(1'b1, OFS_CFG, 32'h5, 4'he, q);
      chk_rd(OFS_CFG, 32'h3);
      wr(OFS_STAT, 32'hffff_ffff);
      chk_rd(OFS_STAT, 32'h0010_0030);
      chk_rd(5'h18, 32'h0);
      // Routing and gain table, pairs flipped on the fly
      foreach (rows[i]) begin
         wr(OFS_CHSEL, {28'h0, rows[i].ch});
         wr(OFS_PAIR, {28'h0, rows[i].pair});
         wr(OFS_CFG, {29'h0, rows[i].g});
         repeat (2) @(posedge clk); #1;
         chk_pin({amp_gain_sel, mux_pos, mux_neg, temp_sel, mux_diff, mux_neg_gnd},
                 rows[i].e, "route");
         bus(1'b0, OFS_STAT, 32'h0, 4'hf, q);
         chk_pin(q[21:5], rows[i].e, "status route");
      end
      // Power: bias alone, then enable, tick pacing, then bias off and disable
      wr(OFS_REF, 32'h1);
      repeat (2) @(posedge clk); #1;
      chk_pin({conv_enable, track_hold_enable, amp_enable, shutdown, bias_on, conv_ready},
              6'b000110, "bias only");
      wr(OFS_CTRL, 32'h1);
      n = 0;
      do begin @(posedge clk); #1; n++; end while (conv_ready !== 1'b1 && n < 10);
      chk_pin({conv_enable, track_hold_enable, amp_enable, shutdown, bias_on, conv_ready},
              6'b111011, "enabled");
      for (int j = 0; j < 2; j++) begin
         n = 0;
         do begin @(posedge clk); #1; n++; end while (sample_tick !== 1'b1 && n < 600);
         chk_pin(n, 500, "tick spacing");
      end
      wr(OFS_REF, 32'h0);
      repeat (2) @(posedge clk); #1;
      chk_pin({conv_enable, track_hold_enable, amp_enable, shutdown, bias_on, conv_ready},
              6'b111000, "no bias");
      wr(OFS_CTRL, 32'h0);
      repeat (2) @(posedge clk); #1;
      chk_pin({conv_enable, track_hold_enable, amp_enable, shutdown, bias_on, conv_ready},
              6'b000100, "shut down");
      // Mid-run reset after non-default settings: pairs and gain must return
      wr(OFS_PAIR, 32'hf);
      wr(OFS_CFG, 32'h4);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk); #1;
      chk_pin({amp_gain_sel, mux_pos, mux_neg, temp_sel, mux_diff, mux_neg_gnd},
              {6'h02, 4'h0, 4'h0, 3'b001}, "mid reset route");
      repeat (2) @(posedge clk);
      chk_rd(OFS_PAIR, 32'h0);
      chk_rd(OFS_CFG, 32'h0);
      finish_test();
   end
endmodule // amg_top_tb
